// ==== design/lpc_pkg.sv ====
// constants shared by the low-power comparator control logic
// assumes an apb master on the single core clock, synchronous reset
package lpc_pkg;
    localparam logic [11:0] task_start_off   = 12'h000;
    localparam logic [11:0] task_stop_off    = 12'h004;
    localparam logic [11:0] task_sample_off  = 12'h008;
    localparam logic [11:0] ev_ready_off     = 12'h100;
    localparam logic [11:0] ev_down_off      = 12'h104;
    localparam logic [11:0] ev_up_off        = 12'h108;
    localparam logic [11:0] ev_cross_off     = 12'h10c;
    localparam logic [11:0] int_set_off      = 12'h304;
    localparam logic [11:0] int_clr_off      = 12'h308;
    localparam logic [11:0] result_off       = 12'h400;
    localparam logic [11:0] enable_off       = 12'h500;
    localparam logic [11:0] input_sel_off    = 12'h504;
    localparam logic [11:0] ref_sel_off      = 12'h508;
    localparam logic [11:0] ext_ref_sel_off  = 12'h50c;
    localparam logic [11:0] detect_cfg_off   = 12'h520;
    localparam logic [11:0] hysteresis_enable_off         = 12'h538;
    localparam logic [11:0] status_off       = 12'h540;
    // event bit positions in status and mask registers
    localparam int ev_ready_bit = 0;
    localparam int ev_down_bit  = 1;
    localparam int ev_up_bit    = 2;
    localparam int ev_cross_bit = 3;
    localparam int num_events   = 4;
    // reset values
    localparam logic [2:0] ref_sel_rst    = 3'h0;
    localparam logic [2:0] input_sel_rst  = 3'h0;
    localparam logic [1:0] detect_cfg_rst = 2'h0;
    // detect source encodings
    localparam logic [1:0] detect_cross = 2'h0;
    localparam logic [1:0] detect_up    = 2'h1;
    localparam logic [1:0] detect_down  = 2'h2;
    // startup time in nanoseconds and the clock rate
    localparam int startup_ns  = 140000;
    localparam int clk_mhz     = 10;
    localparam int startup_cyc = (startup_ns * clk_mhz + 999) / 1000;
    typedef enum logic [1:0] {
        st_off     = 2'b00,
        st_startup = 2'b01,
        st_running = 2'b11
    } cmp_state_t;
endpackage

// ==== design/lpc_sync.sv ====
// two-flop synchroniser for the asynchronous comparator output
// assumes the analog core output may change at any time
module lpc_sync
    import lpc_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic reset_i,
    input  wire logic async_i,
    output logic      sync_o
);
    logic stage1;
    logic next_stage1;
    logic next_sync;

    // first stage feeds only the second stage
    always_comb begin
        next_stage1 = async_i;
        next_sync   = stage1;
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            stage1 <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            stage1 <= next_stage1;
            sync_o <= next_sync;
        end
    end
endmodule

// ==== design/lpc_startup.sv ====
// startup interval counter: pulses done when the interval has elapsed
// assumes start is a one-cycle pulse; abort cancels a running interval
module lpc_startup
    import lpc_pkg::*;
#(
    parameter int count = startup_cyc
) (
    input  wire logic core_clk_i,
    input  wire logic reset_i,
    input  wire logic start_i,
    input  wire logic abort_i,
    output logic      busy_o,
    output logic      done_o
);
    localparam int cw = $clog2(count + 1);
    if (count < 1) begin : bad_count
        $error("startup count must be at least one");
    end
    logic [cw-1:0] cnt;
    logic [cw-1:0] next_cnt;
    logic          next_busy;
    logic          next_done;

    always_comb begin
        next_cnt  = cnt;
        next_busy = busy_o;
        next_done = 1'b0;
        if (abort_i) begin
            next_busy = 1'b0;
        end else if (start_i) begin
            next_busy = 1'b1;
            next_cnt  = cw'(count - 1);
        end else if (busy_o) begin
            if (cnt == '0) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end else begin
                next_cnt = cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            cnt    <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            cnt    <= next_cnt;
            busy_o <= next_busy;
            done_o <= next_done;
        end
    end
endmodule

// ==== design/low_power_comparator.sv ====
// control, event and register logic around the low-power comparator
// assumes apb from software, a power controller giving deep sleep and
// wakeup indications, and an asynchronous analog comparator output
//
// The register offsets and the APB slave port were chosen for this implementation.
module low_power_comparator
    import lpc_pkg::*;
#(
    parameter int startup_count = startup_cyc
) (
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        cmp_out_i,
    input  wire logic        deep_sleep_i,
    input  wire logic        wakeup_i,
    output logic             analog_detect_wake_o,
    output logic             cmp_power_o,
    output logic             pins_acquired_o,
    output logic      [2:0]  input_sel_o,
    output logic      [3:0]  reference_select_o,
    output logic             external_reference_select_o,
    output logic             hysteresis_enable_o,
    output logic             irq_o,
    output logic             ev_ready_o,
    output logic             ev_down_o,
    output logic             ev_up_o,
    output logic             ev_cross_o
);
    logic                  enable;
    logic [num_events-1:0] status;
    logic [num_events-1:0] mask;
    logic                  result;
    logic [1:0]            detect_cfg;
    cmp_state_t            state;
    logic                  cmp_prev;
    logic                  cmp_sync;
    logic                  su_busy;
    logic                  su_done;

    logic                  next_enable;
    logic [num_events-1:0] next_status;
    logic [num_events-1:0] next_mask;
    logic                  next_result;
    logic [1:0]            next_detect_cfg;
    cmp_state_t            next_state;
    logic [2:0]            next_input_sel;
    logic [3:0]            next_ref_sel;
    logic                  next_ext_ref;
    logic                  next_hysteresis_enable;
    logic [31:0]           next_prdata;
    logic                  next_pready;
    logic                  next_pslverr;
    logic [num_events-1:0] ev;
    logic                  next_wake;
    logic                  next_irq;
    logic                  wr;
    logic                  t_start;
    logic                  t_stop;
    logic                  t_sample;
    logic                  wipe;
    logic                  up_edge;
    logic                  down_edge;
    logic                  mapped;

    lpc_sync u_sync (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .async_i    (cmp_out_i),
        .sync_o     (cmp_sync)
    );

    lpc_startup #(.count(startup_count)) u_startup (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .start_i    (t_start),
        .abort_i    (t_stop | wipe),
        .busy_o     (su_busy),
        .done_o     (su_done)
    );

    // a wakeup from deep sleep clears the control, event and register state back to reset values; the apb response flops keep theirs
    assign wipe      = wakeup_i;
    assign wr        = psel_i & penable_i & pwrite_i & pready_o;
    assign t_start   = wr & (paddr_i == task_start_off) & pwdata_i[0]
                       & enable;
    assign t_stop    = wr & (paddr_i == task_stop_off) & pwdata_i[0];
    assign t_sample  = wr & (paddr_i == task_sample_off) & pwdata_i[0];
    // edges only from the synchronised copy, one pulse per crossing
    assign up_edge   = (state == st_running) & cmp_sync & ~cmp_prev;
    assign down_edge = (state == st_running) & ~cmp_sync & cmp_prev;

    always_comb begin
        mapped = 1'b1;
        case (paddr_i)
            task_start_off, task_stop_off, task_sample_off,
            ev_ready_off, ev_down_off, ev_up_off, ev_cross_off,
            int_set_off, int_clr_off, result_off, enable_off,
            input_sel_off, ref_sel_off, ext_ref_sel_off,
            detect_cfg_off, hysteresis_enable_off, status_off: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    always_comb begin
        next_state = state;
        case (state)
            st_off: if (t_start) next_state = st_startup;
            st_startup: begin
                if (t_stop) next_state = st_off;
                else if (su_done) next_state = st_running;
            end
            st_running: if (t_stop) next_state = st_off;
            default: next_state = st_off;
        endcase
        if (wipe | ~enable) next_state = st_off;
    end

    always_comb begin
        ev = '0;
        // during deep sleep only the wake line moves, no events
        if (~deep_sleep_i & ~wakeup_i) begin
            ev[ev_ready_bit] = su_done & (state == st_startup);
            ev[ev_up_bit]    = up_edge;
            ev[ev_down_bit]  = down_edge;
            ev[ev_cross_bit] = up_edge | down_edge;
        end
        next_wake = 1'b0;
        if (deep_sleep_i & enable) begin
            case (detect_cfg)
                detect_up:   next_wake = up_edge;
                detect_down: next_wake = down_edge;
                default:     next_wake = up_edge | down_edge;
            endcase
        end
    end

    always_comb begin
        next_enable     = enable;
        next_mask       = mask;
        next_result     = result;
        next_detect_cfg = detect_cfg;
        next_input_sel  = input_sel_o;
        next_ref_sel    = reference_select_o;
        next_ext_ref    = external_reference_select_o;
        next_hysteresis_enable       = hysteresis_enable_o;
        next_status     = status;
        if (t_sample) next_result = cmp_sync;
        if (wr) begin
            case (paddr_i)
                enable_off:      next_enable = pwdata_i[0];
                input_sel_off:   next_input_sel = pwdata_i[2:0];
                ref_sel_off:     next_ref_sel = pwdata_i[3:0];
                ext_ref_sel_off: next_ext_ref = pwdata_i[0];
                detect_cfg_off:  next_detect_cfg = pwdata_i[1:0];
                hysteresis_enable_off:        next_hysteresis_enable = pwdata_i[0];
                int_set_off:     next_mask = mask | pwdata_i[3:0];
                int_clr_off:     next_mask = mask & ~pwdata_i[3:0];
                status_off:      next_status = status & ~pwdata_i[3:0];
                ev_ready_off:    if (~pwdata_i[0])
                    next_status[ev_ready_bit] = 1'b0;
                ev_down_off:     if (~pwdata_i[0])
                    next_status[ev_down_bit] = 1'b0;
                ev_up_off:       if (~pwdata_i[0])
                    next_status[ev_up_bit] = 1'b0;
                ev_cross_off:    if (~pwdata_i[0])
                    next_status[ev_cross_bit] = 1'b0;
                default: ;
            endcase
        end
        // a new event wins over a clear in the same cycle
        next_status = next_status | ev;
        next_irq    = |(next_status & next_mask);
    end

    always_comb begin
        next_prdata  = '0;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        if (psel_i & ~pready_o) begin
            next_pready  = 1'b1;
            next_pslverr = ~mapped;
            if (~pwrite_i) begin
                case (paddr_i)
                    ev_ready_off: next_prdata = 32'(status[ev_ready_bit]);
                    ev_down_off:  next_prdata = 32'(status[ev_down_bit]);
                    ev_up_off:    next_prdata = 32'(status[ev_up_bit]);
                    ev_cross_off: next_prdata = 32'(status[ev_cross_bit]);
                    status_off:   next_prdata = 32'(status);
                    int_set_off, int_clr_off: next_prdata = 32'(mask);
                    result_off:   next_prdata = 32'(result);
                    enable_off:   next_prdata = 32'(enable);
                    input_sel_off: next_prdata = 32'(input_sel_o);
                    ref_sel_off:  next_prdata = 32'(reference_select_o);
                    ext_ref_sel_off:
                        next_prdata = 32'(external_reference_select_o);
                    detect_cfg_off: next_prdata = 32'(detect_cfg);
                    hysteresis_enable_off:     next_prdata = 32'(hysteresis_enable_o);
                    default:      next_prdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i | wipe) begin
            enable                      <= 1'b0;
            status                      <= '0;
            mask                        <= '0;
            result                      <= 1'b0;
            detect_cfg                  <= detect_cfg_rst;
            state                       <= st_off;
            cmp_prev                    <= 1'b0;
            input_sel_o                 <= input_sel_rst;
            reference_select_o          <= {1'b0, ref_sel_rst};
            external_reference_select_o <= 1'b0;
            hysteresis_enable_o         <= 1'b0;
            cmp_power_o                 <= 1'b0;
            pins_acquired_o             <= 1'b0;
            irq_o                       <= 1'b0;
            analog_detect_wake_o        <= 1'b0;
            ev_ready_o                  <= 1'b0;
            ev_down_o                   <= 1'b0;
            ev_up_o                     <= 1'b0;
            ev_cross_o                  <= 1'b0;
        end else begin
            enable                      <= next_enable;
            status                      <= next_status;
            mask                        <= next_mask;
            result                      <= next_result;
            detect_cfg                  <= next_detect_cfg;
            state                       <= next_state;
            // first run cycle compares against the current level
            cmp_prev                    <= cmp_sync;
            input_sel_o                 <= next_input_sel;
            reference_select_o          <= next_ref_sel;
            external_reference_select_o <= next_ext_ref;
            hysteresis_enable_o         <= next_hysteresis_enable;
            cmp_power_o                 <= next_state != st_off;
            pins_acquired_o             <= next_enable;
            irq_o                       <= next_irq;
            analog_detect_wake_o        <= next_wake;
            ev_ready_o                  <= ev[ev_ready_bit];
            ev_down_o                   <= ev[ev_down_bit];
            ev_up_o                     <= ev[ev_up_bit];
            ev_cross_o                  <= ev[ev_cross_bit];
        end
    end

    // apb reads and writes complete in the first access cycle, with no wait states
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            prdata_o  <= '0;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            prdata_o  <= next_prdata;
            pready_o  <= next_pready;
            pslverr_o <= next_pslverr;
        end
    end

    // cycles since the last start task, saturating; times the ready pulse
    localparam int sw = $clog2(startup_count + 2);
    logic [sw-1:0] since_start;
    logic [sw-1:0] next_since_start;

    always_comb begin
        next_since_start = since_start;
        if (t_start) begin
            next_since_start = '0;
        end else if (since_start != '1) begin
            next_since_start = since_start + 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            since_start <= '0;
        end else begin
            since_start <= next_since_start;
        end
    end

    ready_after_start_a: assert property (@(posedge core_clk_i)
        disable iff (reset_i)
        ev_ready_o |-> since_start == sw'(startup_count + 1))
        else $error("ready not at end of startup");
    up_cross_pair_a: assert property (@(posedge core_clk_i)
        disable iff (reset_i)
        ev_up_o |-> ev_cross_o && !ev_down_o)
        else $error("up event without cross");
    down_cross_pair_a: assert property (@(posedge core_clk_i)
        disable iff (reset_i)
        ev_down_o |-> ev_cross_o && !ev_up_o)
        else $error("down event without cross");
    stop_quiet_a: assert property (@(posedge core_clk_i)
        disable iff (reset_i)
        (t_stop && !t_start) |-> ##2 !ev_cross_o)
        else $error("crossing after stop");
    sample_capture_a: assert property (@(posedge core_clk_i)
        disable iff (reset_i || wipe)
        t_sample |=> result == $past(cmp_sync))
        else $error("sample missed output");
    hysteresis_enable_reset_a: assert property (@(posedge core_clk_i)
        disable iff (reset_i)
        $past(reset_i) |-> !hysteresis_enable_o)
        else $error("hysteresis not reset");
    wake_clears_a: assert property (@(posedge core_clk_i)
        disable iff (reset_i)
        wakeup_i |=> !enable && mask == '0 && status == '0)
        else $error("wakeup kept registers");
    sleep_no_event_a: assert property (@(posedge core_clk_i)
        disable iff (reset_i)
        $past(deep_sleep_i) |-> !ev_cross_o && !ev_ready_o)
        else $error("event during deep sleep");
    pins_follow_a: assert property (@(posedge core_clk_i)
        disable iff (reset_i || wipe)
        $past(enable) != enable |=> pins_acquired_o == $past(enable))
        else $error("pins not following enable");
    single_event_a: assert property (@(posedge core_clk_i)
        disable iff (reset_i)
        ev_cross_o |=> !ev_cross_o || ev_up_o == $past(ev_down_o))
        else $error("crossing pulse repeated");
    wake_source_a: assert property (@(posedge core_clk_i)
        disable iff (reset_i || wipe)
        analog_detect_wake_o |-> $past(deep_sleep_i))
        else $error("wake outside deep sleep");
endmodule

// ==== sim/lpc_analog_model.sv ====
// behavioural analog comparator core that drives the raw comparator output
// assumes the bench sets the input level and the block under test powers it
module lpc_analog_model (
    input  wire logic clk_i,
    input  wire logic power_i,
    input  wire logic above_i,
    output logic      cmp_out_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic junk = 1'b0;
    // an unpowered core output means nothing: toggle it so no edge logic
    // can lean on a stale level
    always @(posedge clk_i) junk <= ~junk;
    // output valid only while started
    assign cmp_out_o = power_i ? above_i : junk;
endmodule

// ==== sim/low_power_comparator_test.sv ====
// self-checking bench for the low-power comparator control block
// assumes apb answered in the access phase, an analog model, startup of 5
module low_power_comparator_test
    import lpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_i = 1'b0, reset_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
    logic pwrite_i = 1'b0, cmp_out_i, deep_sleep_i = 1'b0, wakeup_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rdata;
    logic pready_o, pslverr_o, analog_detect_wake_o, cmp_power_o, err;
    logic pins_acquired_o, external_reference_select_o, hysteresis_enable_o;
    logic [2:0] input_sel_o;
    logic [3:0] reference_select_o;
    logic irq_o, ev_ready_o, ev_down_o, ev_up_o, ev_cross_o, above = 1'b0;
    int n_errors = 0, samples_checked = 0, cnt [5] = '{0, 0, 0, 0, 0};
    int lone = 0, c;
    always #50 core_clk_i = ~core_clk_i;
    low_power_comparator #(.startup_count(5)) low_power_comparator_inst (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .cmp_out_i(cmp_out_i),
        .deep_sleep_i(deep_sleep_i), .wakeup_i(wakeup_i),
        .analog_detect_wake_o(analog_detect_wake_o),
        .cmp_power_o(cmp_power_o), .pins_acquired_o(pins_acquired_o),
        .input_sel_o(input_sel_o), .reference_select_o(reference_select_o),
        .external_reference_select_o(external_reference_select_o),
        .hysteresis_enable_o(hysteresis_enable_o), .irq_o(irq_o),
        .ev_ready_o(ev_ready_o), .ev_down_o(ev_down_o), .ev_up_o(ev_up_o),
        .ev_cross_o(ev_cross_o));
    lpc_analog_model lpc_analog_model_inst (.clk_i(core_clk_i),
        .power_i(cmp_power_o), .above_i(above), .cmp_out_o(cmp_out_i));
    // pulse counters: 0 ready, 1 down, 2 up, 3 cross, 4 wake
    always @(posedge core_clk_i) begin
        if (ev_ready_o === 1'b1) cnt[0]++;
        if (ev_down_o === 1'b1) cnt[1]++;
        if (ev_up_o === 1'b1) cnt[2]++;
        if (ev_cross_o === 1'b1) cnt[3]++;
        if (analog_detect_wake_o === 1'b1) cnt[4]++;
        if ((ev_up_o | ev_down_o) === 1'b1 && ev_cross_o !== 1'b1) lone++;
    end
    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge core_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge core_clk_i);
            if (pready_o === 1'b1) break;
        end
        if (k == 20) begin
            n_errors++;
            $display("ERROR %0t no bus answer", $time);
            test_done();
        end
        rdata = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask
    task automatic wait_ev(input int idx);
        int k, c0;
        c0 = cnt[idx];
        for (k = 0; k < 40 && cnt[idx] == c0; k++) @(posedge core_clk_i);
        chk(32'(cnt[idx] - c0), 32'h1);
        if (k == 40) test_done();
    endtask
    initial begin
        repeat (3) @(posedge core_clk_i);
        reset_i <= 1'b0;
        rd(hysteresis_enable_off, 32'h0);
        rd(enable_off, 32'h0);
        rd(status_off, 32'h0);
        apb(1'b0, 12'h7f0, 32'h0);
        chk({31'h0, err}, 32'h1);
        // settings go in before the enable
        wr(input_sel_off, 32'h5);
        wr(ref_sel_off, 32'he);
        wr(ext_ref_sel_off, 32'h1);
        wr(hysteresis_enable_off, 32'h1);
        @(posedge core_clk_i);
        chk({22'h0, input_sel_o, reference_select_o,
             external_reference_select_o, hysteresis_enable_o,
             pins_acquired_o}, 32'h2f6);
        wr(enable_off, 32'h1);
        rd(enable_off, 32'h1);
        chk({31'h0, pins_acquired_o}, 32'h1);
        wr(int_set_off, 32'hf);
        wr(task_start_off, 32'h1);
        wait_ev(0);
        chk({31'h0, cmp_power_o}, 32'h1);
        rd(status_off, 32'h1);
        chk({31'h0, irq_o}, 32'h1);
        wr(status_off, 32'h1);
        rd(status_off, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        above <= 1'b1;
        wait_ev(2);
        wr(task_sample_off, 32'h1);
        rd(result_off, 32'h1);
        above <= 1'b0;
        wait_ev(1);
        wr(task_sample_off, 32'h1);
        rd(result_off, 32'h0);
        chk(32'(cnt[3]), 32'h2);
        chk(32'(lone), 32'h0);
        rd(status_off, 32'he);
        wr(int_clr_off, 32'hf);
        rd(int_set_off, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        wr(status_off, 32'hf);
        // stopped before any disable unpowered output toggles
        wr(task_stop_off, 32'h1);
        c = cnt[3];
        repeat (30) @(posedge core_clk_i);
        chk(32'(cnt[3] - c), 32'h0);
        chk({31'h0, cmp_power_o}, 32'h0);
        wr(detect_cfg_off, {30'h0, detect_up});
        wr(task_start_off, 32'h1);
        wait_ev(0);
        // deep sleep only after ready has come
        deep_sleep_i <= 1'b1;
        c = cnt[0] + cnt[1] + cnt[2] + cnt[3];
        above <= 1'b1;
        wait_ev(4);
        wr(detect_cfg_off, {30'h0, detect_down});
        above <= 1'b0;
        wait_ev(4);
        wr(detect_cfg_off, {30'h0, detect_cross});
        above <= 1'b1;
        wait_ev(4);
        repeat (4) @(posedge core_clk_i);
        chk(32'(cnt[0] + cnt[1] + cnt[2] + cnt[3] - c), 32'h0);
        wakeup_i <= 1'b1;
        @(posedge core_clk_i);
        wakeup_i <= 1'b0;
        deep_sleep_i <= 1'b0;
        rd(enable_off, 32'h0);
        rd(input_sel_off, 32'h0);
        rd(hysteresis_enable_off, 32'h0);
        chk({31'h0, pins_acquired_o}, 32'h0);
        test_done();
    end
endmodule
